// [verilog/boost_power_state_control.sv]
// Power state, lockout and serial register control of a battery boost regulator.
// Analog comparators and pins arrive asynchronously; outputs steer the power stage.
//
// Operation
// - Chip-on high starts the converter through soft-start, never straight to regulation.
// - Chip-on low shuts down: no switching, control idle, load cut from input.
// - Soft-start is entered only after precharge reports output at least input minus 300mV.
// - Soft-start longer than 2ms without reaching target declares a fault.
// - The level-select pin picks 3.3V (low) or 3.55V (high); serial writes may change both.
// - Every target code maps inside 2.85V to 4.4V.
// - Output below the light-load threshold enters pulse mode, pulsing until the loop exits.
// - Converter waits for input above 1.7V, stops below 1.6V and restarts on recovery.
// - Over-temperature stops operation until it cools below threshold minus hysteresis.
// - Chip-on low turns on the output discharge switch.
// - Valley current over limit stretches off-time; next on-time starts only after it falls.
// - The serial target address is 1110101 for all accesses.
// - The serial port works at fast-mode rates up to 400kb/s.
// - Registers 0x01 to 0x05 are mode, low target, high target, current limit, status.
// - Chip-on high with bypass-force pin low runs current-limited forced pass-through.
`timescale 1ns/100ps
`default_nettype none
module boost_power_state_control
	import boost_pkg::*;
#(
	parameter int SS_TIMEOUT = SS_TIMEOUT_CYC,
	parameter int RESTART    = RESTART_CYC
) (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       chip_on_i,
	input  wire logic       output_level_select_pin_i,
	input  wire logic       bypass_force_low_pin_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       vin_above_rise_i,
	input  wire logic       vin_below_fall_i,
	input  wire logic       temp_over_i,
	input  wire logic       temp_cooled_i,
	input  wire logic       vout_precharged_i,
	input  wire logic       vout_at_target_i,
	input  wire logic       vout_below_light_i,
	input  wire logic       light_load_exit_i,
	input  wire logic       valley_over_i,
	input  wire logic       off_time_end_i,
	output logic            converter_on_o,
	output logic            load_connect_o,
	output logic            precharge_on_o,
	output logic            soft_start_on_o,
	output logic            bypass_on_o,
	output logic            discharge_on_o,
	output logic            off_extend_o,
	output logic            on_start_o,
	output logic            light_load_pulse_o,
	output logic            light_load_pulse_mode_o,
	output logic            power_good_output_o,
	output logic            power_good_output_oe_o,
	output logic            spread_spectrum_on_o,
	output logic [TGT_W-1:0] vout_code_o,
	output logic [7:0]      current_limit_code_o
);
	typedef struct packed {
		power_state_type  pwr;
		logic             low_input_lockout;
		logic             over_temp;
		logic             light_load_pulse_mode;
		logic [7:0]       mode_control;
		logic [TGT_W-1:0] target_low;
		logic [TGT_W-1:0] target_high;
		logic [7:0]       current_limit_setting;
		bus_state_type    bus;
		logic [3:0]       bit_cnt;
		logic [7:0]       shift;
		logic [7:0]       ptr;
		logic             rw;
		logic             scl_prev;
		logic             sda_prev;
		logic             sda_oe;
		logic             cycle_issued;
		logic             converter_on;
		logic             load_connect;
		logic             precharge_on;
		logic             soft_start_on;
		logic             bypass_on;
		logic             discharge_on;
		logic             off_extend;
		logic             on_start;
		logic             light_pulse;
		logic             pg_low;
		logic             spread;
		logic [TGT_W-1:0] vout_code;
		logic [7:0]       ilim_code;
	} state_type;

	state_type st_ff;
	state_type nxt_st;
	pins_type  p;
	logic      ss_expired;
	logic      restart_expired;
	logic      pulse_tick;
	logic      blocked;
	logic      scl_rise;
	logic      scl_fall;
	logic      start_seen;
	logic      stop_seen;

	pin_sync #(.WIDTH($bits(pins_type))) u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i ({chip_on_i, output_level_select_pin_i, bypass_force_low_pin_i, scl_i,
			sda_i, vin_above_rise_i, vin_below_fall_i, temp_over_i, temp_cooled_i,
			vout_precharged_i, vout_at_target_i, vout_below_light_i, light_load_exit_i,
			valley_over_i, off_time_end_i}),
		.level_o (p)
	);

	cycle_timer #(.WIDTH(TIMER_W)) u_ss_timer (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.run_i     (st_ff.pwr == P_SOFT),
		.limit_i   (TIMER_W'(SS_TIMEOUT)),
		.expired_o (ss_expired)
	);

	cycle_timer #(.WIDTH(TIMER_W)) u_restart_timer (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.run_i     (st_ff.pwr == P_FAULT),
		.limit_i   (TIMER_W'(RESTART)),
		.expired_o (restart_expired)
	);

	// Releasing run on the tick restarts the gap, giving a steady pulse train
	cycle_timer #(.WIDTH(TIMER_W)) u_pulse_timer (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.run_i     (st_ff.light_load_pulse_mode & ~pulse_tick),
		.limit_i   (TIMER_W'(PULSE_GAP_CYC)),
		.expired_o (pulse_tick)
	);

	function automatic logic [7:0] reg_value(input state_type s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFS_MODE:   v = s.mode_control;
			OFS_TGT_LO: v = {3'h0, s.target_low};
			OFS_TGT_HI: v = {3'h0, s.target_high};
			OFS_ILIM:   v = s.current_limit_setting;
			OFS_COND: begin
				v[COND_FAULT_BIT] = (s.pwr == P_FAULT);
				v[COND_LOCK_BIT]  = s.low_input_lockout;
				v[COND_OTP_BIT]   = s.over_temp;
				v[COND_PG_BIT]    = ~s.pg_low;
				v[COND_LIGHT_BIT] = s.light_load_pulse_mode;
				v[COND_STATE_LSB +: 3] = s.pwr;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		nxt_st = st_ff;
		blocked = 1'b0;
		scl_rise = p.scl & ~st_ff.scl_prev;
		scl_fall = ~p.scl & st_ff.scl_prev;
		start_seen = st_ff.scl_prev & p.scl & st_ff.sda_prev & ~p.sda;
		stop_seen = st_ff.scl_prev & p.scl & ~st_ff.sda_prev & p.sda;

		// input lockout with hysteresis
		// Set wins over clear so a glitching rail never sneaks a restart
		if (p.vin_fall) begin
			nxt_st.low_input_lockout = 1'b1;
		end else if (p.vin_rise) begin
			nxt_st.low_input_lockout = 1'b0;
		end
		if (p.temp_over) begin
			nxt_st.over_temp = 1'b1;
		end else if (p.temp_cooled) begin
			nxt_st.over_temp = 1'b0;
		end
		blocked = nxt_st.low_input_lockout | nxt_st.over_temp;

		case (st_ff.pwr)
			P_OFF, P_LOCK: begin
				nxt_st.pwr = p.byp_force_low ? P_PRE : P_BYP;
			end
			P_PRE: begin
				if (p.precharged) begin
					nxt_st.pwr = P_SOFT;
				end
			end
			P_SOFT: begin
				if (p.at_target) begin
					nxt_st.pwr = P_RUN;
				end else if (ss_expired) begin
					nxt_st.pwr = P_FAULT;
				end
			end
			P_RUN: begin
				if (!p.byp_force_low) begin
					nxt_st.pwr = P_BYP;
				end
			end
			P_BYP: begin
				if (p.byp_force_low) begin
					nxt_st.pwr = P_PRE;
				end
			end
			P_FAULT: begin
				if (restart_expired) begin
					nxt_st.pwr = P_PRE;
				end
			end
			default: nxt_st.pwr = P_OFF;
		endcase
		if (!p.chip_on) begin
			nxt_st.pwr = P_OFF;
		end else if (blocked) begin
			nxt_st.pwr = P_LOCK;
		end

		if (nxt_st.pwr != P_RUN || st_ff.mode_control[MODE_CTRL_LSB +: 2] == 2'b00) begin
			nxt_st.light_load_pulse_mode = 1'b0;
		end else if (p.below_light) begin
			nxt_st.light_load_pulse_mode = 1'b1;
		end else if (p.light_exit) begin
			nxt_st.light_load_pulse_mode = 1'b0;
		end

		nxt_st.converter_on = (nxt_st.pwr == P_SOFT) || (nxt_st.pwr == P_RUN);
		nxt_st.load_connect = (nxt_st.pwr == P_PRE) || (nxt_st.pwr == P_SOFT) ||
			(nxt_st.pwr == P_RUN) || (nxt_st.pwr == P_BYP);
		nxt_st.precharge_on = (nxt_st.pwr == P_PRE);
		nxt_st.soft_start_on = (nxt_st.pwr == P_SOFT);
		nxt_st.bypass_on = (nxt_st.pwr == P_BYP);
		nxt_st.discharge_on = ~p.chip_on;

		nxt_st.off_extend = nxt_st.converter_on & p.valley_over;
		nxt_st.on_start = nxt_st.converter_on & p.off_end & ~p.valley_over &
			~st_ff.cycle_issued;
		if (!p.off_end) begin
			nxt_st.cycle_issued = 1'b0;
		end else if (nxt_st.on_start) begin
			nxt_st.cycle_issued = 1'b1;
		end
		nxt_st.light_pulse = pulse_tick & nxt_st.light_load_pulse_mode;

		nxt_st.pg_low = ~(((nxt_st.pwr == P_RUN) && p.at_target) ||
			(st_ff.mode_control[MODE_PG_BIT] && (nxt_st.pwr == P_BYP)));
		nxt_st.spread = st_ff.mode_control[MODE_SPREAD_BIT];
		nxt_st.ilim_code = st_ff.current_limit_setting;
		// 5-bit code spans the whole window only
		nxt_st.vout_code = p.level_sel ? st_ff.target_high : st_ff.target_low;

		nxt_st.scl_prev = p.scl;
		nxt_st.sda_prev = p.sda;
		if (stop_seen) begin
			nxt_st.bus = I_IDLE;
			nxt_st.sda_oe = 1'b0;
		end else if (start_seen) begin
			nxt_st.bus = I_ADDR;
			nxt_st.bit_cnt = 4'h0;
			nxt_st.sda_oe = 1'b0;
		end else begin
			case (st_ff.bus)
				I_ADDR, I_REG, I_WR: begin
					if (scl_rise) begin
						nxt_st.shift = {st_ff.shift[6:0], p.sda};
						nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
					end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
						nxt_st.bit_cnt = 4'h0;
						nxt_st.sda_oe = 1'b1;
						nxt_st.bus = I_RACK;
						if (st_ff.bus == I_ADDR) begin
							if (st_ff.shift[7:1] != DEV_ADDR) begin
								nxt_st.bus = I_IDLE;
								nxt_st.sda_oe = 1'b0;
							end else begin
								nxt_st.rw = st_ff.shift[0];
								nxt_st.bus = I_AACK;
								nxt_st.shift = reg_value(st_ff, st_ff.ptr);
							end
						end else if (st_ff.bus == I_REG) begin
							nxt_st.ptr = st_ff.shift;
						end else begin
							nxt_st.ptr = st_ff.ptr + 8'h01;
							case (st_ff.ptr)
								OFS_MODE: begin
									if (st_ff.shift[MODE_RESET_BIT]) begin
										nxt_st.mode_control = MODE_RST;
										nxt_st.target_low = TGT_LO_RST;
										nxt_st.target_high = TGT_HI_RST;
										nxt_st.current_limit_setting = ILIM_RST;
									end else begin
										nxt_st.mode_control = st_ff.shift;
									end
								end
								OFS_TGT_LO: nxt_st.target_low = st_ff.shift[TGT_W-1:0];
								OFS_TGT_HI: nxt_st.target_high = st_ff.shift[TGT_W-1:0];
								OFS_ILIM: nxt_st.current_limit_setting = st_ff.shift;
								default: nxt_st.ptr = st_ff.ptr + 8'h01;
							endcase
						end
					end
				end
				I_AACK: begin
					if (scl_fall) begin
						nxt_st.bus = st_ff.rw ? I_RD : I_REG;
						nxt_st.sda_oe = st_ff.rw & ~st_ff.shift[7];
					end
				end
				I_RACK: begin
					if (scl_fall) begin
						nxt_st.bus = I_WR;
						nxt_st.sda_oe = 1'b0;
					end
				end
				I_RD: begin
					if (scl_rise) begin
						nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (st_ff.bit_cnt == 4'h8) begin
							nxt_st.bit_cnt = 4'h0;
							nxt_st.sda_oe = 1'b0;
							nxt_st.bus = I_MACK;
						end else begin
							nxt_st.shift = {st_ff.shift[6:0], 1'b0};
							nxt_st.sda_oe = ~st_ff.shift[6];
						end
					end
				end
				I_MACK: begin
					if (scl_rise) begin
						if (p.sda) begin
							nxt_st.bus = I_IDLE;
						end else begin
							nxt_st.ptr = st_ff.ptr + 8'h01;
							nxt_st.shift = reg_value(st_ff, st_ff.ptr + 8'h01);
							nxt_st.bus = I_AACK;
						end
					end
				end
				default: nxt_st.bus = I_IDLE;
			endcase
		end
	end

	// Bus lines reset high so the first sampled level cannot fake a start
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.pwr <= P_OFF;
			st_ff.bus <= I_IDLE;
			st_ff.low_input_lockout <= 1'b1;
			st_ff.mode_control <= MODE_RST;
			st_ff.target_low <= TGT_LO_RST;
			st_ff.target_high <= TGT_HI_RST;
			st_ff.current_limit_setting <= ILIM_RST;
			st_ff.scl_prev <= 1'b1;
			st_ff.sda_prev <= 1'b1;
			st_ff.discharge_on <= 1'b1;
			st_ff.pg_low <= 1'b1;
			st_ff.vout_code <= TGT_LO_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = st_ff.sda_oe;
	assign converter_on_o = st_ff.converter_on;
	assign load_connect_o = st_ff.load_connect;
	assign precharge_on_o = st_ff.precharge_on;
	assign soft_start_on_o = st_ff.soft_start_on;
	assign bypass_on_o = st_ff.bypass_on;
	assign discharge_on_o = st_ff.discharge_on;
	assign off_extend_o = st_ff.off_extend;
	assign on_start_o = st_ff.on_start;
	assign light_load_pulse_o = st_ff.light_pulse;
	assign light_load_pulse_mode_o = st_ff.light_load_pulse_mode;
	assign power_good_output_o = 1'b0;
	assign power_good_output_oe_o = st_ff.pg_low;
	assign spread_spectrum_on_o = st_ff.spread;
	assign vout_code_o = st_ff.vout_code;
	assign current_limit_code_o = st_ff.ilim_code;
endmodule
`default_nettype wire

// [pkg/boost_pkg.sv]
// Constants, register map and shared types of the boost power controller.
// Assumes a 250 MHz system clock; all pins arrive asynchronously.
package boost_pkg;

	localparam int CLK_MHZ       = 250;
	localparam int SS_TIMEOUT_US = 2000;
	localparam int SS_TIMEOUT_CYC = SS_TIMEOUT_US * CLK_MHZ;
	localparam int RESTART_US    = 1000;
	localparam int RESTART_CYC   = RESTART_US * CLK_MHZ;
	localparam int PULSE_GAP_NS  = 400;
	localparam int PULSE_GAP_CYC = (PULSE_GAP_NS * CLK_MHZ) / 1000;
	localparam int TIMER_W       = 20;

	localparam logic [6:0] DEV_ADDR = 7'h75;

	localparam logic [7:0] OFS_MODE = 8'h01;
	localparam logic [7:0] OFS_TGT_LO = 8'h02;
	localparam logic [7:0] OFS_TGT_HI = 8'h03;
	localparam logic [7:0] OFS_ILIM = 8'h04;
	localparam logic [7:0] OFS_COND = 8'h05;

	localparam logic [7:0] MODE_RST   = 8'h09;
	localparam logic [4:0] TGT_LO_RST = 5'h09;
	localparam logic [4:0] TGT_HI_RST = 5'h0e;
	localparam logic [7:0] ILIM_RST   = 8'h00;

	localparam int MODE_RESET_BIT = 7;
	localparam int MODE_PG_BIT    = 3;
	localparam int MODE_SPREAD_BIT = 2;
	localparam int MODE_CTRL_LSB  = 0;
	localparam int TGT_W          = 5;

	localparam int COND_FAULT_BIT = 0;
	localparam int COND_LOCK_BIT  = 1;
	localparam int COND_OTP_BIT   = 2;
	localparam int COND_PG_BIT    = 3;
	localparam int COND_LIGHT_BIT = 4;
	localparam int COND_STATE_LSB = 5;

	typedef enum logic [2:0] {
		P_OFF   = 3'b000,
		P_LOCK  = 3'b001,
		P_PRE   = 3'b010,
		P_SOFT  = 3'b011,
		P_RUN   = 3'b100,
		P_BYP   = 3'b101,
		P_FAULT = 3'b110
	} power_state_type;

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_AACK = 3'b010,
		I_REG  = 3'b011,
		I_RACK = 3'b100,
		I_WR   = 3'b101,
		I_RD   = 3'b110,
		I_MACK = 3'b111
	} bus_state_type;

	typedef struct packed {
		logic chip_on;
		logic level_sel;
		logic byp_force_low;
		logic scl;
		logic sda;
		logic vin_rise;
		logic vin_fall;
		logic temp_over;
		logic temp_cooled;
		logic precharged;
		logic at_target;
		logic below_light;
		logic light_exit;
		logic valley_over;
		logic off_end;
	} pins_type;

endpackage

// [verilog/pin_sync.sv]
// Three-stage synchroniser bank for asynchronous pins.
// The output moves only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] level_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} sync_type;

	sync_type st_ff;
	sync_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = async_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// Bitwise agree test keeps a glitching pin from flipping the level
		for (int i = 0; i < WIDTH; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.level[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level_o = st_ff.level;
endmodule
`default_nettype wire

// [verilog/cycle_timer.sv]
// Run-gated cycle counter; expired_o rises one cycle after limit is reached.
// Dropping run_i clears it, so callers restart it by releasing run_i.
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
	parameter int WIDTH = 20
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             run_i,
	input  wire logic [WIDTH-1:0] limit_i,
	output logic                  expired_o
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic             expired;
	} timer_type;

	timer_type st_ff;
	timer_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (!run_i) begin
			nxt_st = '0;
		end else if (st_ff.cnt == limit_i) begin
			nxt_st.expired = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign expired_o = st_ff.expired;
endmodule
`default_nettype wire

// [bench/serial_host.sv]
// Two-wire bus host model: start, stop and byte transfers, MSB first.
// SDA is open drain with a pull-up; the bench resolves the wire level.
`timescale 1ns/100ps
`default_nettype none
module serial_host #(
	parameter int H = 313
) (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// Serves as repeated start too, since it first releases SDA
	task automatic start();
		sda_pull_o <= 1'b0;
		tick(H / 2);
		scl_o <= 1'b1;
		tick(H / 2);
		sda_pull_o <= 1'b1;
		tick(H / 2);
		scl_o <= 1'b0;
		tick(H / 2);
	endtask
	task automatic stop();
		sda_pull_o <= 1'b1;
		tick(H / 2);
		scl_o <= 1'b1;
		tick(H / 2);
		sda_pull_o <= 1'b0;
		tick(H);
	endtask
	// bit time H plus 2*(H/2)
	// High lasts H cycles and low 2*(H/2): 625 cycles, 400 kb/s, never faster
	task automatic bit_io(input logic b, output logic r);
		sda_pull_o <= !b;
		tick(H / 2);
		scl_o <= 1'b1;
		tick(H);
		r = sda_i;
		scl_o <= 1'b0;
		tick(H / 2);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(rel, ack);
	endtask
endmodule
`default_nettype wire

// [bench/boost_chk.sv]
// Concurrent checks on the power state outputs of the boost controller.
// Bound to the top module; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module boost_chk #(
	parameter int SS_TIMEOUT = 200
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic chip_on_i,
	input wire logic vin_below_fall_i,
	input wire logic temp_over_i,
	input wire logic converter_on_o,
	input wire logic load_connect_o,
	input wire logic precharge_on_o,
	input wire logic soft_start_on_o,
	input wire logic bypass_on_o,
	input wire logic discharge_on_o,
	input wire logic off_extend_o,
	input wire logic on_start_o,
	input wire logic light_load_pulse_o,
	input wire logic light_load_pulse_mode_o
);
	int unsigned soft_cnt_ff;
	int unsigned nxt_soft_cnt;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	always_comb nxt_soft_cnt = soft_start_on_o ? soft_cnt_ff + 1 : 0;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			soft_cnt_ff <= 0;
		end else begin
			soft_cnt_ff <= nxt_soft_cnt;
		end
	end
	// Sync delay is up to five cycles, so eight settled samples are asked for
	AST_SOFT_FIRST: assert property ($rose(converter_on_o) |-> soft_start_on_o)
		else $error("switching began outside soft-start");
	AST_SHUTDOWN: assert property (!chip_on_i [*8] |-> !converter_on_o && !load_connect_o)
		else $error("active while chip-on low");
	AST_SOFT_AFTER_PRE: assert property ($rose(soft_start_on_o) |-> $past(precharge_on_o))
		else $error("soft-start not entered from precharge");
	AST_SS_LIMIT: assert property (soft_cnt_ff <= SS_TIMEOUT + 4)
		else $error("soft-start outlasted its timeout");
	AST_PULSE_IN_MODE: assert property (light_load_pulse_o |-> light_load_pulse_mode_o)
		else $error("light-load pulse outside pulse mode");
	AST_PULSE_GAP: assert property (light_load_pulse_o |=> !light_load_pulse_o [*8])
		else $error("light-load pulses too close");
	AST_LOCKOUT: assert property (vin_below_fall_i [*8] |-> !load_connect_o)
		else $error("running with low input");
	AST_OVERTEMP: assert property (temp_over_i [*8] |-> !load_connect_o)
		else $error("running while over temperature");
	AST_DISCHARGE: assert property ($stable(chip_on_i) [*8] |-> discharge_on_o == !chip_on_i)
		else $error("discharge switch not opposite chip-on");
	AST_VALLEY: assert property (off_extend_o |-> !on_start_o)
		else $error("on-time started during extended off-time");
	AST_ON_PULSE: assert property (on_start_o |=> !on_start_o)
		else $error("on-time start longer than one cycle");
	AST_BYPASS: assert property (bypass_on_o |-> !converter_on_o && load_connect_o)
		else $error("pass-through mode not clean");
endmodule
bind boost_power_state_control boost_chk #(.SS_TIMEOUT(SS_TIMEOUT)) boost_chk_i (.*);
`default_nettype wire

// [bench/boost_power_state_control_bench.sv]
// Self-checking bench: reset map, serial writes, then the power sequence.
// Pins change just after clock edges; the host model works the serial port.
`timescale 1ns/100ps
`default_nettype none
module boost_power_state_control_bench;
	logic clock_i, rst_i, chip_on_i, output_level_select_pin_i, bypass_force_low_pin_i;
	logic scl_i, sda_pull, vin_above_rise_i, vin_below_fall_i, temp_over_i, temp_cooled_i;
	logic vout_precharged_i, vout_at_target_i, vout_below_light_i, light_load_exit_i;
	logic valley_over_i, off_time_end_i, sda_o, sda_oe_o, converter_on_o, load_connect_o;
	logic precharge_on_o, soft_start_on_o, bypass_on_o, discharge_on_o, off_extend_o;
	logic on_start_o, light_load_pulse_o, light_load_pulse_mode_o, power_good_output_o;
	logic power_good_output_oe_o, spread_spectrum_on_o;
	logic [4:0] vout_code_o;
	logic [7:0] current_limit_code_o;
	logic [7:0] k;
	wire logic sda_i;
	int fails = 0;
	int n_tests = 0;
	boost_power_state_control #(.SS_TIMEOUT(200), .RESTART(100)) boost_power_state_control_i (.*);
	serial_host host_i (.clock_i(clock_i), .sda_i(sda_i), .scl_o(scl_i), .sda_pull_o(sda_pull));
	assign sda_i = (sda_pull || (sda_oe_o && !sda_o)) ? 1'b0 : 1'b1;
	always #2 clock_i = ~clock_i;
	initial begin
		repeat (98000) @(posedge clock_i);
		fails++;
		wrap_up();
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// A byte of 8'hff is a read; any other byte is a write whose ack is checked
	task automatic io(input logic [7:0] tx, input logic rel, input logic [7:0] exp);
		logic [7:0] rx;
		logic ack;
		host_i.xfer(tx, rel, rx, ack);
		chk(tx == 8'hff ? "rdata" : "ack", exp, tx == 8'hff ? rx : 8'(ack));
	endtask
	task automatic wrap_up();
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		rst_i = 1'b1;
		{chip_on_i, output_level_select_pin_i, vin_above_rise_i, vin_below_fall_i} = '0;
		{temp_over_i, temp_cooled_i, vout_precharged_i, vout_at_target_i} = '0;
		{vout_below_light_i, light_load_exit_i, valley_over_i, off_time_end_i} = '0;
		bypass_force_low_pin_i = 1'b1;
		wt(6);
		rst_i <= 1'b0;
		wt(10);
		chk("vout_lo", 8'h09, 8'(vout_code_o));
		chk("disch", 8'h01, 8'(discharge_on_o));
		output_level_select_pin_i <= 1'b1;
		wt(8);
		chk("vout_hi", 8'h0e, 8'(vout_code_o));
		chk("sda_oe_rst", 8'h00, 8'(sda_oe_o));
		chk("pg_oe_rst", 8'h01, 8'(power_good_output_oe_o));
		chk("pg_pin", 8'h00, 8'(power_good_output_o));
		chk("ilim_rst", 8'h00, current_limit_code_o);
		chk("spread_rst", 8'h00, 8'(spread_spectrum_on_o));
		output_level_select_pin_i <= 1'b0;
		// Writes come first so one read burst checks every stored value; keeps the run short
		host_i.start();
		io(8'hea, 1'b1, 8'h00);
		io(8'h01, 1'b1, 8'h00);
		io(8'h0d, 1'b1, 8'h00);
		io(8'h3f, 1'b1, 8'h00);
		io(8'hf3, 1'b1, 8'h00);
		io(8'h5a, 1'b1, 8'h00);
		host_i.stop();
		wt(10);
		chk("spread", 8'h01, 8'(spread_spectrum_on_o));
		chk("vout_lo_w", 8'h1f, 8'(vout_code_o));
		chk("ilim", 8'h5a, current_limit_code_o);
		output_level_select_pin_i <= 1'b1;
		wt(8);
		chk("vout_hi_w", 8'h13, 8'(vout_code_o));
		host_i.start();
		io(8'hea, 1'b1, 8'h00);
		io(8'h01, 1'b1, 8'h00);
		host_i.start();
		io(8'heb, 1'b1, 8'h00);
		io(8'hff, 1'b0, 8'h0d);
		io(8'hff, 1'b0, 8'h1f);
		io(8'hff, 1'b0, 8'h13);
		io(8'hff, 1'b0, 8'h5a);
		io(8'hff, 1'b1, 8'h02);
		host_i.stop();
		host_i.start();
		io(8'hec, 1'b1, 8'h01);
		host_i.stop();
		chip_on_i <= 1'b1;
		wt(10);
		chk("lock_load", 8'h00, 8'(load_connect_o));
		vin_above_rise_i <= 1'b1;
		wt(8);
		chk("pre", 8'h01, 8'(precharge_on_o));
		chk("soft_early", 8'h00, 8'(soft_start_on_o));
		chk("disch_off", 8'h00, 8'(discharge_on_o));
		vout_precharged_i <= 1'b1;
		wt(8);
		chk("soft", 8'h01, 8'(soft_start_on_o));
		wt(185);
		chk("ss_hold", 8'h01, 8'(converter_on_o));
		wt(20);
		chk("ss_fault", 8'h00, 8'(converter_on_o));
		vout_at_target_i <= 1'b1;
		wt(120);
		chk("restart", 8'h01, 8'(converter_on_o));
		chk("run", 8'h00, 8'(soft_start_on_o));
		chk("pg_run", 8'h00, 8'(power_good_output_oe_o));
		// Light-load pulses come every 102 cycles, so a 306 cycle window holds three
		vout_below_light_i <= 1'b1;
		wt(8);
		chk("ll_mode", 8'h01, 8'(light_load_pulse_mode_o));
		k = 8'h00;
		repeat (306) begin
			@(posedge clock_i);
			k = k + 8'(light_load_pulse_o);
		end
		chk("ll_pulses", 8'h03, k);
		vout_below_light_i <= 1'b0;
		light_load_exit_i <= 1'b1;
		wt(8);
		chk("ll_exit", 8'h00, 8'(light_load_pulse_mode_o));
		light_load_exit_i <= 1'b0;
		// Valley raised first so the two syncs cannot race into a stray start
		valley_over_i <= 1'b1;
		wt(2);
		off_time_end_i <= 1'b1;
		wt(8);
		chk("extend", 8'h01, 8'(off_extend_o));
		valley_over_i <= 1'b0;
		k = 8'h00;
		repeat (10) begin
			@(posedge clock_i);
			k = k + 8'(on_start_o);
		end
		chk("one_start", 8'h01, k);
		off_time_end_i <= 1'b0;
		bypass_force_low_pin_i <= 1'b0;
		wt(8);
		chk("byp", 8'h01, 8'(bypass_on_o));
		chk("byp_load", 8'h01, 8'(load_connect_o));
		bypass_force_low_pin_i <= 1'b1;
		wt(12);
		vin_below_fall_i <= 1'b1;
		vin_above_rise_i <= 1'b0;
		wt(8);
		chk("uv_off", 8'h00, 8'(load_connect_o));
		vin_below_fall_i <= 1'b0;
		wt(10);
		chk("uv_hold", 8'h00, 8'(converter_on_o));
		vin_above_rise_i <= 1'b1;
		wt(12);
		chk("uv_back", 8'h01, 8'(converter_on_o));
		temp_over_i <= 1'b1;
		wt(8);
		chk("ot_off", 8'h00, 8'(load_connect_o));
		temp_over_i <= 1'b0;
		wt(10);
		chk("ot_hold", 8'h00, 8'(converter_on_o));
		temp_cooled_i <= 1'b1;
		wt(12);
		chk("ot_back", 8'h01, 8'(converter_on_o));
		temp_cooled_i <= 1'b0;
		chip_on_i <= 1'b0;
		wt(8);
		chk("shut_sw", 8'h00, 8'(converter_on_o));
		chk("shut_load", 8'h00, 8'(load_connect_o));
		chk("shut_disch", 8'h01, 8'(discharge_on_o));
		wrap_up();
	end
endmodule
`default_nettype wire
